// file: hw/recb_pkg.sv
// Package with register map, field layout, reset values and timing for the reset event counter bank
package recb_pkg;
    localparam int CNT_W = 8;
    localparam int ADDR_W = 12;
    // Register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_COUNT_RD = 12'h07f;
    localparam logic [ADDR_W-1:0] IDX_COUNT_WR = 12'h03f;
    localparam logic [ADDR_W-1:0] IDX_DELAY = 12'h010;
    localparam logic [ADDR_W-1:0] IDX_CTRL = 12'h011;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h012;
    // Field positions
    localparam int CTRL_AUTO_BIT = 0;
    localparam int STAT_ANSWER_BIT = 1;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_INRST_BIT = 2;
    // Reset values and special codes
    localparam logic [CNT_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [CNT_W-1:0] DELAY_RESET = 8'hff;
    localparam logic [CNT_W-1:0] DELAY_DISABLED = 8'hff;
    localparam logic [CNT_W-1:0] DELAY_INVALID = 8'h00;
    localparam logic CTRL_AUTO_RESET = 1'b0;
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int STEP_MS = 100;
    localparam int STEP_CYC = (CLK_HZ / 1000) * STEP_MS;
    localparam int WD_HOLD_CYC = 4;
    typedef enum logic [1:0] {
        T_IDLE,
        T_WAIT,
        T_ANSWER
    } recb_tstate_t;
endpackage : recb_pkg

// file: hw/recb_core_if.sv
// Interface joining the bank's register logic to its counter and answer timer
interface recb_core_if;
    logic       cnt_inc;
    logic       cnt_wr;
    logic [7:0] cnt_wdata;
    logic [7:0] count;
    logic       tm_rst;
    logic       auto_en;
    logic [7:0] delay_code;
    logic       offhook;
    logic       flash;
    logic       answer;
    logic       running;
    modport ctrl (
        output cnt_inc, cnt_wr, cnt_wdata, tm_rst, auto_en, delay_code, offhook, flash,
        input  count, answer, running
    );
    modport counter (
        input  cnt_inc, cnt_wr, cnt_wdata,
        output count
    );
    modport timer (
        input  tm_rst, auto_en, delay_code, offhook, flash,
        output answer, running
    );
endinterface : recb_core_if

// file: hw/recb_counter.sv
// Eight-bit reset event counter with clear, preset and wrap
module recb_counter (
    input  wire logic   clock_i,
    input  wire logic   rst_b_i,
    recb_core_if.counter core
);
    import recb_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    // Release and write in one cycle: the release is counted on top of the written value
    assign next_count = core.cnt_wr ? core.cnt_wdata + (core.cnt_inc ? 8'h01 : 8'h00)
                                    : count + (core.cnt_inc ? 8'h01 : 8'h00);

    // Only the power-up reset clears it; module resets leave it alone
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            count <= COUNT_RESET;
        end else begin
            count <= next_count;
        end
    end
    assign core.count = count;

    a_count_wrap: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        core.cnt_inc && !core.cnt_wr && count == 8'hff |=> count == 8'h00)
        else $error("counter did not wrap to zero");
    a_count_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        core.cnt_wr && core.cnt_wdata == 8'h00 && !core.cnt_inc |=> count == 8'h00)
        else $error("zero write did not clear counter");
    a_count_preset: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        core.cnt_wr && !core.cnt_inc |=> count == $past(core.cnt_wdata))
        else $error("preset value not loaded");
    a_count_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !core.cnt_wr && !core.cnt_inc |=> $stable(count))
        else $error("counter changed with no cause");
endmodule // recb_counter

// file: hw/recb_answer_timer.sv
// Answer delay timer for automatic flash answer operation
module recb_answer_timer #(
    parameter int STEP_CYCLES = recb_pkg::STEP_CYC
) (
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    recb_core_if.timer core
);
    import recb_pkg::*;

    localparam int CYC_W = $clog2(STEP_CYCLES + 1);
    recb_tstate_t state;
    recb_tstate_t next_state;
    logic [CYC_W-1:0] cyc;
    logic [7:0]       steps;
    logic             answer;
    logic             running;
    logic [31:0]      elapsed;
    wire code_ok = core.delay_code != DELAY_INVALID && core.delay_code != DELAY_DISABLED;
    wire timing = state == T_WAIT && core.auto_en && code_ok;
    wire step_end = cyc == CYC_W'(STEP_CYCLES - 1);
    wire expired = timing && step_end && steps == core.delay_code - 8'h01;

    always_comb begin
        next_state = state;
        unique case (state)
            T_IDLE: if (core.offhook) next_state = T_WAIT;
            T_WAIT: begin
                if (!core.offhook) next_state = T_IDLE;
                else if (core.flash || expired) next_state = T_ANSWER;
            end
            T_ANSWER: if (!core.offhook) next_state = T_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i || core.tm_rst) begin
            state <= T_IDLE;
            cyc <= '0;
            steps <= 8'h00;
            answer <= 1'b0;
            running <= 1'b0;
        end else begin
            state <= next_state;
            cyc <= (!timing || step_end) ? '0 : cyc + CYC_W'(1);
            steps <= !timing ? 8'h00 : steps + (step_end ? 8'h01 : 8'h00);
            answer <= next_state == T_ANSWER;
            running <= next_state == T_WAIT && core.auto_en && code_ok;
        end
    end
    assign core.answer = answer;
    assign core.running = running;

    // Helper for the delay check only
    always_ff @(posedge clock_i) begin
        elapsed <= (state == T_WAIT) ? elapsed + 32'd1 : 32'd0;
    end

    a_delay_exact: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $rose(answer) && !$past(core.flash) && !$past(core.tm_rst)
        |-> elapsed == 32'(core.delay_code) * 32'(STEP_CYCLES))
        else $error("answer delay differs from code times step");
    a_delay_disabled: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        state == T_WAIT && !code_ok && !core.flash |=> !answer)
        else $error("answer issued with delay disabled");
endmodule // recb_answer_timer

// file: hw/recb_bank.sv
// Top of the reset event counter bank: APB slave, module reset tracking and answer delay control
//
// The APB register port was chosen for this implementation.
import recb_pkg::*;

// What this block does
// - A count of module resets is kept and survives every module reset; of all resets, only power-up clears it.
// - Writing zero to the counter's write location clears the count.
// - Power-up, the external reset pin and watchdog expiry each advance the count.
// - The count reads at location 0x7F and is loaded by a write to location 0x3F.
// - The count advances at each release of module reset and a nonzero write presets it.
// - With automatic flash answer the answer follows off-hook by the code times 100 ms; 0xFF disables it, 0 is invalid.
module recb_bank #(
    parameter int STEP_CYCLES = recb_pkg::STEP_CYC
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [recb_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                 pwdata_i,
    output logic      [31:0]                 prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    input  wire logic                        module_reset_pin_i,
    input  wire logic                        watchdog_expire_i,
    input  wire logic                        offhook_i,
    input  wire logic                        hook_flash_i,
    output logic                             answer_o,
    output logic                             module_in_reset_o
);
    import recb_pkg::*;

    recb_core_if core ();

    // Module reset tracking
    logic [2:0]       wd_hold;
    logic             in_reset;
    logic             was_in_reset;
    logic [CNT_W-1:0] delay_code;
    logic             auto_en;
    logic [31:0]      next_rdata;

    // A watchdog expiry holds the module in reset for a few cycles, like a short pin pulse
    wire wd_active = wd_hold != 3'h0;
    wire next_in_reset = module_reset_pin_i || watchdog_expire_i || wd_active;
    // Power-up leaves was_in_reset set, so the first free cycle counts too
    wire reset_release = was_in_reset && !in_reset;

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            wd_hold <= 3'h0;
        end else if (watchdog_expire_i) begin
            wd_hold <= 3'(WD_HOLD_CYC - 1);
        end else if (wd_active) begin
            wd_hold <= wd_hold - 3'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            in_reset <= 1'b1;
            was_in_reset <= 1'b1;
        end else begin
            in_reset <= next_in_reset;
            was_in_reset <= in_reset;
        end
    end
    assign module_in_reset_o = in_reset;

    // APB address decode
    wire [ADDR_W-3:0] idx = paddr_i[ADDR_W-1:2];
    wire hit_count_rd = idx == IDX_COUNT_RD[ADDR_W-3:0];
    wire hit_count_wr = idx == IDX_COUNT_WR[ADDR_W-3:0];
    wire hit_delay = idx == IDX_DELAY[ADDR_W-3:0];
    wire hit_ctrl = idx == IDX_CTRL[ADDR_W-3:0];
    wire hit_status = idx == IDX_STATUS[ADDR_W-3:0];
    wire rd_ok = hit_count_rd || hit_delay || hit_ctrl || hit_status;
    wire wr_ok = hit_count_wr || hit_delay || hit_ctrl;
    wire dec_ok = pwrite_i ? wr_ok : rd_ok;

    // One wait state: the access phase lasts two cycles
    wire next_ready = psel_i && penable_i && !pready_o;
    wire wr_fire = psel_i && penable_i && pready_o && pwrite_i;
    // Writes are dropped while the module sits in reset, as all its functions are down
    wire wr_live = wr_fire && !in_reset;
    wire wr_count = wr_live && hit_count_wr;
    wire wr_delay = wr_live && hit_delay && pwdata_i[7:0] != DELAY_INVALID;
    wire wr_ctrl = wr_live && hit_ctrl;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_count_rd) begin
            next_rdata[7:0] = core.count;
        end else if (hit_delay) begin
            next_rdata[7:0] = delay_code;
        end else if (hit_ctrl) begin
            next_rdata[CTRL_AUTO_BIT] = auto_en;
        end else if (hit_status) begin
            next_rdata[STAT_RUN_BIT] = core.running;
            next_rdata[STAT_ANSWER_BIT] = core.answer;
            next_rdata[STAT_INRST_BIT] = in_reset;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= next_ready;
            pslverr_o <= next_ready && !dec_ok;
            if (next_ready && !pwrite_i && rd_ok) begin
                prdata_o <= next_rdata;
            end else if (next_ready) begin
                prdata_o <= 32'h0000_0000;
            end
        end
    end

    // Settings fall back to factory defaults while the module is in reset
    always_ff @(posedge clock_i) begin
        if (!rst_b_i || in_reset) begin
            delay_code <= DELAY_RESET;
            auto_en <= CTRL_AUTO_RESET;
        end else begin
            if (wr_delay) begin
                delay_code <= pwdata_i[7:0];
            end
            if (wr_ctrl) begin
                auto_en <= pwdata_i[CTRL_AUTO_BIT];
            end
        end
    end

    // Core connections
    assign core.cnt_inc = reset_release;
    assign core.cnt_wr = wr_count;
    assign core.cnt_wdata = pwdata_i[7:0];
    assign core.tm_rst = in_reset;
    assign core.auto_en = auto_en;
    assign core.delay_code = delay_code;
    assign core.offhook = offhook_i;
    assign core.flash = hook_flash_i;
    assign answer_o = core.answer;

    recb_counter u_counter (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .core    (core.counter)
    );

    recb_answer_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_timer (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .core    (core.timer)
    );

    a_release_counts: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $fell(module_reset_pin_i) && !watchdog_expire_i && !wd_active && !$past(watchdog_expire_i)
        |=> core.cnt_inc)
        else $error("reset release was not counted");
    a_watchdog_counts: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        watchdog_expire_i && !module_reset_pin_i |-> ##[1:8] core.cnt_inc)
        else $error("watchdog reset was not counted");
    a_count_readback: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        psel_i && penable_i && !pready_o && !pwrite_i && hit_count_rd
        |=> prdata_o == {24'h000000, $past(core.count)})
        else $error("count read data wrong");
    a_count_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        wr_fire && hit_count_wr && !in_reset && !core.cnt_inc |=> core.count == $past(pwdata_i[7:0]))
        else $error("count write at 0x3f not loaded");
    a_zero_delay_kept: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        wr_fire && hit_delay && pwdata_i[7:0] == 8'h00 && !in_reset |=> delay_code == $past(delay_code))
        else $error("invalid delay code accepted");
    a_count_survives: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        in_reset && !core.cnt_inc && !core.cnt_wr |=> core.count == $past(core.count))
        else $error("count lost during module reset");
endmodule // recb_bank

// file: bench/recb_bank_tb.sv
// Self-checking testbench for the reset event counter bank
module recb_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import recb_pkg::*;

    // Short step so the answer delay fits a brief run
    localparam int STEP = 10;
    localparam logic [ADDR_W-1:0] A_RD  = ADDR_W'(IDX_COUNT_RD << 2);
    localparam logic [ADDR_W-1:0] A_WR  = ADDR_W'(IDX_COUNT_WR << 2);
    localparam logic [ADDR_W-1:0] A_DLY = ADDR_W'(IDX_DELAY << 2);
    localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'(IDX_CTRL << 2);
    localparam logic [ADDR_W-1:0] A_ST  = ADDR_W'(IDX_STATUS << 2);

    logic              clock_i, rst_b_i, psel_i, penable_i, pwrite_i;
    logic              pin_i, wd_i, offhook_i, flash_i;
    logic [ADDR_W-1:0] paddr_i;
    logic [31:0]       pwdata_i, prdata_o, v;
    logic              pready_o, pslverr_o, answer_o, in_rst_o, ans_prev;
    logic [33:0]       bus_q[$];
    logic [33:0]       e;
    int                ans_q[$];
    int                fail_count, total_checks, cyc;

    recb_bank #(.STEP_CYCLES(STEP)) i_dut (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .module_reset_pin_i(pin_i),
        .watchdog_expire_i(wd_i), .offhook_i(offhook_i), .hook_flash_i(flash_i),
        .answer_o(answer_o), .module_in_reset_o(in_rst_o)
    );

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk_bus(input logic [33:0] x);
        total_checks++;
        if (pslverr_o !== x[32] || (x[33] && prdata_o !== x[31:0])) begin
            $display("ERROR bus response expected %h seen %h", x[32:0], {pslverr_o, prdata_o});
            fail_count++;
        end
    endtask

    task automatic chk_time(input int exp_cyc, input int seen);
        total_checks++;
        if (exp_cyc != seen) begin
            $display("ERROR answer cycle expected %0d seen %0d", exp_cyc, seen);
            fail_count++;
        end
    endtask

    // Write sends d; read expects d when chk is set
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic chk, input logic err);
        bus_q.push_back({chk, err, d});
        @(posedge clock_i);
        psel_i   <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clock_i);
        end while (pready_o !== 1'b1);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Module reset by pin or watchdog, optionally writing while held
    task automatic mreset(input logic wd, input logic dowr);
        int n;
        n = 0;
        @(posedge clock_i);
        if (wd) wd_i <= 1'b1;
        else pin_i <= 1'b1;
        @(posedge clock_i);
        wd_i <= 1'b0;
        while (in_rst_o !== 1'b1 && n < 10) begin
            @(posedge clock_i);
            n++;
        end
        if (dowr) begin
            apb(1'b1, A_WR, 32'h55, 1'b0, 1'b0);
            apb(1'b0, A_ST, 32'h1 << STAT_INRST_BIT, 1'b1, 1'b0);
        end
        pin_i <= 1'b0;
        n = 0;
        while (in_rst_o !== 1'b0 && n < 20) begin
            @(posedge clock_i);
            n++;
        end
        repeat (2) @(posedge clock_i);
    endtask

    // Monitor: pairs each response with the oldest note
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        ans_prev <= answer_o;
        if (pready_o === 1'b1 && psel_i && penable_i && bus_q.size() > 0) begin
            e = bus_q.pop_front();
            chk_bus(e);
        end
        if (answer_o === 1'b1 && ans_prev !== 1'b1) begin
            if (ans_q.size() == 0) chk_time(-1, cyc);
            else chk_time(ans_q.pop_front(), cyc);
        end
    end

    initial begin
        #(40 * 5000);
        $display("ERROR run_time expected done seen timeout");
        fail_count++;
        conclude();
    end

    initial begin
        {psel_i, penable_i, pwrite_i, pin_i, wd_i, offhook_i, flash_i, rst_b_i} = '0;
        paddr_i  = '0;
        pwdata_i = '0;
        cyc      = 0;
        ans_prev = 1'b0;
        v = $urandom(32'h139b7efb);
        repeat (12) @(posedge clock_i);
        rst_b_i <= 1'b1;
        apb(1'b0, A_RD, 32'h01, 1'b1, 1'b0);
        apb(1'b0, A_DLY, 32'hff, 1'b1, 1'b0);
        apb(1'b0, A_CTL, 32'h00, 1'b1, 1'b0);
        apb(1'b0, A_ST, 32'h00, 1'b1, 1'b0);
        $display("test power_up done");
        mreset(1'b0, 1'b1);
        apb(1'b0, A_RD, 32'h02, 1'b1, 1'b0);
        mreset(1'b1, 1'b0);
        apb(1'b0, A_RD, 32'h03, 1'b1, 1'b0);
        $display("test reset_causes done");
        v = 32'($urandom_range(254, 1));
        apb(1'b1, A_WR, v, 1'b0, 1'b0);
        apb(1'b0, A_RD, v, 1'b1, 1'b0);
        apb(1'b1, A_WR, 32'h00, 1'b0, 1'b0);
        apb(1'b0, A_RD, 32'h00, 1'b1, 1'b0);
        apb(1'b0, A_WR, 32'h00, 1'b1, 1'b1);
        apb(1'b1, A_RD, 32'h07, 1'b0, 1'b1);
        apb(1'b0, 12'h300, 32'h00, 1'b1, 1'b1);
        $display("test preset_clear done");
        apb(1'b1, A_WR, 32'hff, 1'b0, 1'b0);
        mreset(1'b0, 1'b0);
        apb(1'b0, A_RD, 32'h00, 1'b1, 1'b0);
        $display("test wrap done");
        apb(1'b1, A_DLY, 32'h00, 1'b0, 1'b0);
        apb(1'b0, A_DLY, 32'hff, 1'b1, 1'b0);
        apb(1'b1, A_DLY, 32'h03, 1'b0, 1'b0);
        apb(1'b1, A_CTL, 32'h01, 1'b0, 1'b0);
        @(posedge clock_i);
        offhook_i <= 1'b1;
        ans_q.push_back(cyc + 2 + 3 * STEP);
        repeat (3 * STEP + 6) @(posedge clock_i);
        offhook_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        $display("test timed_answer done");
        apb(1'b1, A_DLY, 32'hff, 1'b0, 1'b0);
        @(posedge clock_i);
        offhook_i <= 1'b1;
        repeat (40) @(posedge clock_i);
        flash_i <= 1'b1;
        ans_q.push_back(cyc + 2);
        @(posedge clock_i);
        flash_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        offhook_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        $display("test disabled_delay done");
        if (ans_q.size() != 0 || bus_q.size() != 0) begin
            $display("ERROR pending_notes expected 0 seen %0d", ans_q.size() + bus_q.size());
            fail_count++;
        end
        conclude();
    end
endmodule // recb_bank_tb
